// File: rtl/mise_pkg.sv
// Package of constants and types for the instruction subset executor
package mise_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_TPL = 8'h0C;
  localparam logic [7:0] REG_TPH = 8'h10;
  localparam logic [7:0] REG_THL = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_HIPTR_BIT = 0;
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_AC_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_OV_BIT = 3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] TPL_RST = 8'h00;
  localparam logic [3:0] TPH_RST = 4'h0;
  localparam logic [7:0] THL_RST = 8'h00;
  localparam logic CTRL_RST = 1'b0;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam logic [3:0] LAST_PAGE = 4'hF;
  localparam int SKIP_CYCLES = 2;
  // ---------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MISE_OP_NOP = 4'b0000,
    MISE_OP_SUB_MEM = 4'b0001,
    MISE_OP_SUB_TO_MEM = 4'b0010,
    MISE_OP_SUB_IMM = 4'b0011,
    MISE_OP_SWAP = 4'b0100,
    MISE_OP_SWAP_TO_ACC = 4'b0101,
    MISE_OP_SKZ = 4'b0110,
    MISE_OP_COPY_SKZ = 4'b0111,
    MISE_OP_SKZ_BIT = 4'b1000,
    MISE_OP_TAB_PAGED = 4'b1001,
    MISE_OP_TAB_LAST = 4'b1010,
    MISE_OP_XOR_MEM = 4'b1011,
    MISE_OP_XOR_TO_MEM = 4'b1100,
    MISE_OP_XOR_IMM = 4'b1101
  } mise_op_t;
  typedef enum logic [1:0] {
    MISE_ST_IDLE = 2'b00,
    MISE_ST_ROM = 2'b01,
    MISE_ST_DUMMY = 2'b10
  } mise_state_t;
endpackage

// File: rtl/mise_alu_if.sv
// Interface between executor and its arithmetic unit
`timescale 1ns/100ps
interface mise_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] diff;
  logic borrow_inv;
  logic half_borrow;
  logic signed_range;
  logic [7:0] x;
  logic [7:0] swapped;
  modport core (output a, output b, input diff, input borrow_inv,
    input half_borrow, input signed_range, input x, input swapped);
  modport unit (input a, input b, output diff, output borrow_inv,
    output half_borrow, output signed_range, output x, output swapped);
endinterface

// File: rtl/mise_alu.sv
// Arithmetic unit: subtract, exclusive-or, nibble swap
`timescale 1ns/100ps
module mise_alu (
  mise_alu_if.unit alu
);
  logic [8:0] full;
  logic [4:0] low;
  always_comb begin
    full = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
    low = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
  end
  assign alu.diff = full[7:0];
  assign alu.borrow_inv = full[8];
  assign alu.half_borrow = low[4];
  // Overflow when operands differ in sign and result sign flips
  assign alu.signed_range = (alu.a[7] ^ alu.b[7]) & (alu.a[7] ^ full[7]);
  assign alu.x = alu.a ^ alu.b;
  assign alu.swapped = {alu.b[3:0], alu.b[7:4]};
endmodule

// File: rtl/mise_exec.sv
// Executor for the subtract, swap, skip, table read and xor subset
//
// What this block does
// - Acc minus memory into acc, four flags
// - Acc minus memory into memory, four flags
// - Acc minus immediate into acc, four flags
// - Swap memory nibbles in place, flags kept
// - Swapped memory nibbles into acc, memory kept
// - Zero memory byte skips via dummy cycle
// - Copy memory to acc, skip if zero
// - Selected memory bit zero skips next
// - High pointer on: ROM at both pointers
// - High pointer off: current page, low pointer
// - Last page ROM read, low pointer index
// - Acc xor memory into acc, zero flag
// - Acc xor memory into memory, zero flag
// - Acc xor immediate into acc, zero flag
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module mise_exec (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ins_valid,
  input wire logic [3:0] ins_op,
  input wire logic [7:0] ins_imm,
  input wire logic [7:0] ins_addr,
  input wire logic [2:0] ins_bit,
  input wire logic [3:0] cur_page,
  output logic ins_ready,
  output logic discard_fetch,
  output logic mem_rd,
  output logic [7:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic rom_rd,
  output logic [11:0] rom_addr,
  input wire logic [14:0] rom_data,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    mise_pkg::mise_state_t st;
    logic [7:0] acc;
    logic [3:0] flags;
    logic [7:0] tpl;
    logic [3:0] tph;
    logic [7:0] thl;
    logic hiptr;
    logic [7:0] dst;
    logic ready;
    logic discard;
    logic mrd;
    logic [7:0] maddr;
    logic mwe;
    logic [7:0] mwdata;
    logic rrd;
    logic [11:0] raddr;
    logic [31:0] dat;
    logic ack;
    logic [7:0] ops;
  } mise_state_s_t;

  mise_state_s_t s;
  mise_state_s_t next_s;
  mise_alu_if alu ();

  mise_alu u_alu (
    .alu(alu)
  );

  mise_pkg::mise_op_t op;
  logic [7:0] operand;
  logic use_imm;
  logic wb_req;
  logic wb_wr;
  logic [7:0] wb_off;

  always_comb begin
    op = mise_pkg::mise_op_t'(ins_op);
    use_imm = (op == mise_pkg::MISE_OP_SUB_IMM) ||
      (op == mise_pkg::MISE_OP_XOR_IMM);
    operand = use_imm ? ins_imm : mem_rdata;
    wb_req = wb_cyc_i & wb_stb_i & ~s.ack;
    wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    wb_off = wb_adr_i[7:0];
  end

  assign alu.a = s.acc;
  assign alu.b = operand;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.mwe = 1'b0;
    next_s.rrd = 1'b0;
    next_s.discard = 1'b0;
    next_s.ack = 1'b0;
    next_s.mrd = 1'b0;
    // Register bus, one cycle answer
    if (wb_req) begin
      next_s.ack = 1'b1;
      next_s.dat = 32'h0000_0000;
      case (wb_off)
        mise_pkg::REG_CTRL: next_s.dat[0] = s.hiptr;
        mise_pkg::REG_ACC: next_s.dat[7:0] = s.acc;
        mise_pkg::REG_FLAGS: next_s.dat[3:0] = s.flags;
        mise_pkg::REG_TPL: next_s.dat[7:0] = s.tpl;
        mise_pkg::REG_TPH: next_s.dat[3:0] = s.tph;
        mise_pkg::REG_THL: next_s.dat[7:0] = s.thl;
        mise_pkg::REG_STAT: next_s.dat[7:0] = s.ops;
        default: next_s.dat = 32'h0000_0000;
      endcase
      if (wb_wr) begin
        case (wb_off)
          mise_pkg::REG_CTRL:
            next_s.hiptr = wb_dat_i[mise_pkg::CTRL_HIPTR_BIT];
          mise_pkg::REG_ACC: next_s.acc = wb_dat_i[7:0];
          mise_pkg::REG_FLAGS: next_s.flags = wb_dat_i[3:0];
          mise_pkg::REG_TPL: next_s.tpl = wb_dat_i[7:0];
          mise_pkg::REG_TPH: next_s.tph = wb_dat_i[3:0];
          default: next_s.ops = s.ops;
        endcase
      end
    end
    case (s.st)
      mise_pkg::MISE_ST_IDLE: begin
        next_s.ready = 1'b1;
        if (ins_valid && s.ready) begin
          next_s.ops = s.ops + 8'h01;
          next_s.maddr = ins_addr;
          next_s.mwdata = s.mwdata;
          case (op)
            mise_pkg::MISE_OP_SUB_MEM,
            mise_pkg::MISE_OP_SUB_IMM: begin
              next_s.acc = alu.diff;
              next_s.flags[mise_pkg::FLAG_C_BIT] = alu.borrow_inv;
              next_s.flags[mise_pkg::FLAG_AC_BIT] = alu.half_borrow;
              next_s.flags[mise_pkg::FLAG_OV_BIT] = alu.signed_range;
              next_s.flags[mise_pkg::FLAG_Z_BIT] =
                (alu.diff == 8'h00);
            end
            mise_pkg::MISE_OP_SUB_TO_MEM: begin
              next_s.mwe = 1'b1;
              next_s.mwdata = alu.diff;
              next_s.flags[mise_pkg::FLAG_C_BIT] = alu.borrow_inv;
              next_s.flags[mise_pkg::FLAG_AC_BIT] = alu.half_borrow;
              next_s.flags[mise_pkg::FLAG_OV_BIT] = alu.signed_range;
              next_s.flags[mise_pkg::FLAG_Z_BIT] = (alu.diff == 8'h00);
            end
            mise_pkg::MISE_OP_SWAP: begin
              next_s.mwe = 1'b1;
              next_s.mwdata = alu.swapped;
            end
            mise_pkg::MISE_OP_SWAP_TO_ACC:
              next_s.acc = alu.swapped;
            mise_pkg::MISE_OP_SKZ: begin
              if (mem_rdata == 8'h00) begin
                next_s.discard = 1'b1;
                next_s.ready = 1'b0;
                next_s.st = mise_pkg::MISE_ST_DUMMY;
              end
            end
            mise_pkg::MISE_OP_COPY_SKZ: begin
              next_s.acc = mem_rdata;
              if (mem_rdata == 8'h00) begin
                next_s.discard = 1'b1;
                next_s.ready = 1'b0;
                next_s.st = mise_pkg::MISE_ST_DUMMY;
              end
            end
            mise_pkg::MISE_OP_SKZ_BIT: begin
              if (!mem_rdata[ins_bit]) begin
                next_s.discard = 1'b1;
                next_s.ready = 1'b0;
                next_s.st = mise_pkg::MISE_ST_DUMMY;
              end
            end
            mise_pkg::MISE_OP_TAB_PAGED: begin
              next_s.rrd = 1'b1;
              next_s.dst = ins_addr;
              next_s.ready = 1'b0;
              next_s.st = mise_pkg::MISE_ST_ROM;
              if (s.hiptr) begin
                next_s.raddr = {s.tph, s.tpl};
              end else begin
                next_s.raddr = {cur_page, s.tpl};
              end
            end
            mise_pkg::MISE_OP_TAB_LAST: begin
              next_s.rrd = 1'b1;
              next_s.dst = ins_addr;
              next_s.ready = 1'b0;
              next_s.st = mise_pkg::MISE_ST_ROM;
              next_s.raddr = {mise_pkg::LAST_PAGE, s.tpl};
            end
            mise_pkg::MISE_OP_XOR_MEM,
            mise_pkg::MISE_OP_XOR_IMM: begin
              next_s.acc = alu.x;
              next_s.flags[mise_pkg::FLAG_Z_BIT] =
                (alu.x == 8'h00);
            end
            mise_pkg::MISE_OP_XOR_TO_MEM: begin
              next_s.mwe = 1'b1;
              next_s.mwdata = alu.x;
              next_s.flags[mise_pkg::FLAG_Z_BIT] = (alu.x == 8'h00);
            end
            default: next_s.ops = s.ops;
          endcase
        end
      end
      mise_pkg::MISE_ST_ROM: begin
        // ROM word taken in the same cycle as the read strobe
        next_s.mwe = 1'b1;
        next_s.maddr = s.dst;
        next_s.mwdata = rom_data[7:0];
        next_s.thl = {1'b0, rom_data[14:8]};
        next_s.ready = 1'b1;
        next_s.st = mise_pkg::MISE_ST_IDLE;
      end
      mise_pkg::MISE_ST_DUMMY: begin
        // Dummy cycle replaces the discarded fetch
        next_s.ready = 1'b1;
        next_s.st = mise_pkg::MISE_ST_IDLE;
      end
      default: begin
        next_s.st = mise_pkg::MISE_ST_IDLE;
        next_s.ready = 1'b0;
      end
    endcase
    // Bus read of memory address for operand mirror
    next_s.mrd = 1'b1;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.st <= mise_pkg::MISE_ST_IDLE;
      s.acc <= mise_pkg::ACC_RST;
      s.flags <= mise_pkg::FLAGS_RST;
      s.tpl <= mise_pkg::TPL_RST;
      s.tph <= mise_pkg::TPH_RST;
      s.thl <= mise_pkg::THL_RST;
      s.hiptr <= mise_pkg::CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  assign ins_ready = s.ready;
  assign discard_fetch = s.discard;
  assign mem_rd = s.mrd;
  assign mem_addr = s.maddr;
  assign mem_we = s.mwe;
  assign mem_wdata = s.mwdata;
  assign rom_rd = s.rrd;
  assign rom_addr = s.raddr;
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
endmodule

// File: sim/mise_exec_properties.sv
// Port checker of the instruction subset executor
`timescale 1ns/100ps
module mise_exec_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ins_valid,
  input wire logic [3:0] ins_op,
  input wire logic [7:0] ins_addr,
  input wire logic [2:0] ins_bit,
  input wire logic ins_ready,
  input wire logic discard_fetch,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic rom_rd,
  input wire logic [11:0] rom_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic tk;
  assign tk = ins_valid && ins_ready;
  sequence skip_s;
    discard_fetch && !ins_ready ##1 ins_ready;
  endsequence
  AST_SKIP_ZERO: assert property (
    tk && ins_op == mise_pkg::MISE_OP_SKZ && mem_rdata == 8'h00 |=> skip_s)
    else $error("No skip on zero byte");
  AST_NO_SKIP: assert property (
    tk && ins_op == mise_pkg::MISE_OP_SKZ && mem_rdata != 8'h00
    |=> !discard_fetch && ins_ready) else $error("Skip on nonzero byte");
  AST_COPY_SKIP: assert property (
    tk && ins_op == mise_pkg::MISE_OP_COPY_SKZ && mem_rdata == 8'h00
    |=> skip_s) else $error("No skip on copied zero");
  AST_BIT_SKIP: assert property (
    tk && ins_op == mise_pkg::MISE_OP_SKZ_BIT && !mem_rdata[ins_bit]
    |=> skip_s) else $error("No skip on zero bit");
  AST_MEM_WRITE: assert property (
    tk && (ins_op == mise_pkg::MISE_OP_SUB_TO_MEM
    || ins_op == mise_pkg::MISE_OP_XOR_TO_MEM
    || ins_op == mise_pkg::MISE_OP_SWAP)
    |=> mem_we && mem_addr == $past(ins_addr)) else $error("No write back");
  AST_SWAP_DATA: assert property (
    tk && ins_op == mise_pkg::MISE_OP_SWAP |=> mem_wdata ==
    {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}) else $error("Bad swap");
  AST_ACC_ONLY: assert property (
    tk && (ins_op == mise_pkg::MISE_OP_SWAP_TO_ACC
    || ins_op == mise_pkg::MISE_OP_XOR_MEM
    || ins_op == mise_pkg::MISE_OP_SUB_MEM) |=> !mem_we)
    else $error("Memory written by acc op");
  AST_TAB_LAST: assert property (
    tk && ins_op == mise_pkg::MISE_OP_TAB_LAST |=> rom_rd
    && rom_addr[11:8] == mise_pkg::LAST_PAGE ##1 !rom_rd)
    else $error("Bad last page read");
  AST_TAB_PAGED: assert property (
    tk && ins_op == mise_pkg::MISE_OP_TAB_PAGED |=> rom_rd && !ins_ready
    ##1 mem_we && ins_ready) else $error("Bad paged table read");
endmodule

// File: sim/mise_mem_model.sv
// Data memory and program ROM facing the executor
`timescale 1ns/100ps
module mise_mem_model (
  input wire logic clk,
  input wire logic [7:0] ins_addr,
  output logic [7:0] mem_rdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic rom_rd,
  input wire logic [11:0] rom_addr,
  output logic [14:0] rom_data
);
  logic [7:0] mem [256];
  logic [14:0] rom_word;
  assign mem_rdata = mem[ins_addr];
  // ROM word holds page, low index bits and inverted index
  assign rom_word = {rom_addr[11:8], rom_addr[2:0], ~rom_addr[7:0]};
  // Word valid while the strobe stands, inverse otherwise
  assign rom_data = rom_rd ? rom_word : ~rom_word;
  always @(posedge clk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// File: sim/mise_exec_tb.sv
// Self-checking bench of the instruction subset executor
`timescale 1ns/100ps
module mise_exec_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ins_valid = 1'b0;
  logic [3:0] ins_op = 4'h0;
  logic [7:0] ins_imm = 8'h00, ins_addr = 8'h00;
  logic [2:0] ins_bit = 3'h0;
  logic [3:0] cur_page = 4'h3;
  logic ins_ready, discard_fetch, mem_rd, mem_we, rom_rd, wb_ack_o, disc;
  logic [7:0] mem_addr, mem_rdata, mem_wdata;
  logic [11:0] rom_addr;
  logic [14:0] rom_data;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'hF;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  int failures = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  mise_exec DUT (.clk, .rstn, .ins_valid, .ins_op, .ins_imm, .ins_addr,
    .ins_bit, .cur_page, .ins_ready, .discard_fetch, .mem_rd, .mem_addr,
    .mem_rdata, .mem_we, .mem_wdata, .rom_rd, .rom_addr, .rom_data,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o);
  mise_mem_model u_mem (.clk, .ins_addr, .mem_rdata, .mem_we, .mem_addr,
    .mem_wdata, .rom_rd, .rom_addr, .rom_data);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic limit(input int i);
    if (i == 20) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    wb_we_i <= we;
    wb_adr_i <= {24'h000000, a};
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    limit(i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic run(input mise_pkg::mise_op_t op, input logic [7:0] a,
    input logic [7:0] imm);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ins_ready === 1'b1) break;
    end
    limit(i);
    ins_op <= op;
    ins_addr <= a;
    ins_imm <= imm;
    ins_valid <= 1'b1;
    @(posedge clk);
    ins_valid <= 1'b0;
    @(posedge clk);
    disc = discard_fetch;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdchk(mise_pkg::REG_ACC, 32'h0);
    rdchk(mise_pkg::REG_THL, 32'h0);
    rdchk(8'h40, 32'h0);
    wb(1'b1, mise_pkg::REG_ACC, 32'h10);
    u_mem.mem[1] = 8'h20;
    run(mise_pkg::MISE_OP_SUB_MEM, 8'h01, 8'h00);
    check(mem_rd, 32'h1);
    rdchk(mise_pkg::REG_ACC, 32'hF0);
    rdchk(mise_pkg::REG_FLAGS, 32'h2);
    wb(1'b1, mise_pkg::REG_ACC, 32'h80);
    run(mise_pkg::MISE_OP_SUB_IMM, 8'h00, 8'h01);
    rdchk(mise_pkg::REG_ACC, 32'h7F);
    rdchk(mise_pkg::REG_FLAGS, 32'h9);
    u_mem.mem[2] = 8'h7F;
    run(mise_pkg::MISE_OP_SUB_TO_MEM, 8'h02, 8'h00);
    rdchk(mise_pkg::REG_FLAGS, 32'h7);
    check(u_mem.mem[2], 32'h0);
    u_mem.mem[3] = 8'hA5;
    run(mise_pkg::MISE_OP_SWAP, 8'h03, 8'h00);
    rdchk(mise_pkg::REG_FLAGS, 32'h7);
    check(u_mem.mem[3], 32'h5A);
    u_mem.mem[4] = 8'h3C;
    run(mise_pkg::MISE_OP_SWAP_TO_ACC, 8'h04, 8'h00);
    rdchk(mise_pkg::REG_ACC, 32'hC3);
    check(u_mem.mem[4], 32'h3C);
    u_mem.mem[5] = 8'hC3;
    run(mise_pkg::MISE_OP_XOR_MEM, 8'h05, 8'h00);
    rdchk(mise_pkg::REG_ACC, 32'h0);
    run(mise_pkg::MISE_OP_XOR_IMM, 8'h00, 8'h55);
    rdchk(mise_pkg::REG_ACC, 32'h55);
    rdchk(mise_pkg::REG_FLAGS, 32'h3);
    u_mem.mem[6] = 8'h0F;
    run(mise_pkg::MISE_OP_XOR_TO_MEM, 8'h06, 8'h00);
    rdchk(mise_pkg::REG_FLAGS, 32'h3);
    check(u_mem.mem[6], 32'h5A);
    u_mem.mem[7] = 8'h00;
    u_mem.mem[8] = 8'h01;
    u_mem.mem[9] = 8'hFB;
    run(mise_pkg::MISE_OP_SKZ, 8'h07, 8'h00);
    check(disc, 32'h1);
    run(mise_pkg::MISE_OP_SKZ, 8'h08, 8'h00);
    check(disc, 32'h0);
    run(mise_pkg::MISE_OP_COPY_SKZ, 8'h07, 8'h00);
    check(disc, 32'h1);
    rdchk(mise_pkg::REG_ACC, 32'h0);
    ins_bit <= 3'h2;
    run(mise_pkg::MISE_OP_SKZ_BIT, 8'h09, 8'h00);
    check(disc, 32'h1);
    ins_bit <= 3'h3;
    run(mise_pkg::MISE_OP_SKZ_BIT, 8'h09, 8'h00);
    check(disc, 32'h0);
    wb(1'b1, mise_pkg::REG_TPL, 32'h34);
    wb(1'b1, mise_pkg::REG_TPH, 32'h5);
    wb(1'b1, mise_pkg::REG_CTRL, 32'h1);
    run(mise_pkg::MISE_OP_TAB_PAGED, 8'h0A, 8'h00);
    rdchk(mise_pkg::REG_THL, 32'h2C);
    check(u_mem.mem[10], 32'hCB);
    wb(1'b1, mise_pkg::REG_CTRL, 32'h0);
    run(mise_pkg::MISE_OP_TAB_PAGED, 8'h0B, 8'h00);
    rdchk(mise_pkg::REG_THL, 32'h1C);
    check(u_mem.mem[11], 32'hCB);
    run(mise_pkg::MISE_OP_TAB_LAST, 8'h0C, 8'h00);
    rdchk(mise_pkg::REG_THL, 32'h7C);
    check(u_mem.mem[12], 32'hCB);
    give_verdict();
  end
endmodule
bind mise_exec mise_exec_properties u_props (.clk, .rstn, .ins_valid,
  .ins_op, .ins_addr, .ins_bit, .ins_ready, .discard_fetch, .mem_rdata,
  .mem_we, .mem_addr, .mem_wdata, .rom_rd, .rom_addr);
